// >>> conv_pkg.sv
// Function
// [R1] three 8-bit line delays, each programmable from 0 to 1120 cycles
// [R2] each line delay length is set by a software-written control register
// [R3] samples run through the delays in series; each delay output feeds one filter (code: window mode only; in line mode every filter takes in_q)
// [R4] with bypass set, passthrough equals the input delayed by two cycles
// [R5] without bypass, passthrough latency is five cycles plus the three lengths
// [R6] third delay zero, only last third-filter coefficient set: result is input plus 47
// [R7] cascade input to cascade result takes exactly six cycles
// [R8] array runs as one 21-stage line or as a 3 by 7 window
// [R9] all taps of a filter see one sample; each adds the registered previous tap
// [R10] each filter output passes one delay stage before the next filter
// [R11] 8-bit coefficients in two banks; a bank bit picks the active one
// [R12] changing the active bank never stalls, drops or corrupts samples
// [R13] continuous swap exchanges the banks after every sample
// [R14] data and coefficient formats are each signed or unsigned by choice
// [R15] partial products are kept at full precision, no truncation or rounding
// [R16] the result is a 22-bit two's complement word
// [R17] chained devices form 21N-tap lines or 7X by 3Y windows
// [R18] array output goes through a shifter, then adds cascade input or zero
// [R19] a bank change lands on a sample boundary for every tap alike
package conv_pkg;
  localparam int DATA_W = 8;
  localparam int COEF_W = 8;
  localparam int ACC_W = 22;
  localparam int MAX_LEN = 1120;
  localparam int LEN_W = 11;
  localparam int TAPS = 7;
  localparam int FILTERS = 3;
  localparam int BANKS = 2;
  localparam int ADDR_W = 12;
  // fixed pipeline figures
  localparam int BYPASS_DELAY = 2;
  localparam int CHAIN_FIXED = 5;
  localparam int CASCADE_LAT = 6;
  localparam int ARRAY_LAT = 47;
  localparam int PT_PAD = CHAIN_FIXED - 2;
  localparam int ARRAY_PAD = ARRAY_LAT - 3;
  localparam int CIN_PAD = CASCADE_LAT - 1;
  localparam int SH_MAX = 8;
  localparam int AGE_MAX = 7;
  // register offsets
  localparam logic [ADDR_W-1:0] OFS_LEN_FIRST = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LEN_STEP = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SYS = 12'h00c;
  localparam logic [ADDR_W-1:0] OFS_ARR = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_BACKEND = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h018;
  localparam logic [3:0] COEF_PAGE = 4'h1;
  localparam int COEF_PAGE_LSB = 8;
  localparam int COEF_BANK_BIT = 7;
  localparam int COEF_FILT_LSB = 5;
  localparam int COEF_FILT_W = 2;
  localparam int COEF_TAP_LSB = 2;
  localparam int COEF_TAP_W = 3;
  // field positions
  localparam int SYS_SWAP_BIT = 0;
  localparam int SYS_BYPASS_BIT = 1;
  localparam int SYS_DSIGN_BIT = 2;
  localparam int SYS_CSIGN_BIT = 3;
  localparam int ARR_BANK_BIT = 0;
  localparam int ARR_2D_BIT = 1;
  localparam int BE_ZERO_BIT = 0;
  localparam int BE_SH_LSB = 1;
  localparam int BE_SH_W = 4;
  localparam int BE_LEFT_BIT = 5;
  localparam int BE_W = 6;
  localparam int ST_BANK_BIT = 0;
  localparam int ST_OVF_BIT = 1;
  localparam int ST_ROOM_BIT = 2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic coef_signed;
    logic data_signed;
    logic bypass;
    logic swap;
  } sys_ctrl_t;

  localparam sys_ctrl_t SYS_RESET = 4'h0;
endpackage

// >>> convolver_shift_mac_array.sv
`timescale 1ns/1ps
module convolver_shift_mac_array import conv_pkg::*; #(
  parameter int LINE_DEPTH = MAX_LEN,
  parameter int FIFO_DEPTH = 32
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire reg_req_t i_reg_req,
  output logic [31:0] o_reg_rdata,
  input wire logic [DATA_W-1:0] i_line_chain_input,
  input wire logic i_sample_valid,
  output logic [DATA_W-1:0] o_line_chain_passthrough,
  input wire logic [ACC_W-1:0] i_cascade_in_bus,
  output logic [ACC_W-1:0] o_cascade_result_bus,
  output logic o_result_accept,
  output logic o_result_valid,
  input wire logic i_result_ready,
  output logic [ACC_W-1:0] o_result_data
);
  localparam int LAW = $clog2(LINE_DEPTH);

  function automatic logic [LEN_W-1:0] clamp_len(input logic [31:0] v);
    return (v > 32'(LINE_DEPTH)) ? LEN_W'(LINE_DEPTH) : v[LEN_W-1:0];
  endfunction

  // read index that yields a word written len cycles earlier
  function automatic logic [LAW-1:0] tap_addr(input logic [LAW-1:0] wp,
                                               input logic [LEN_W-1:0] len);
    int v;
    v = int'(wp) - int'(len) + 1;
    if (v < 0) v = v + LINE_DEPTH;
    return LAW'(v);
  endfunction

  function automatic logic signed [ACC_W-1:0] mac_prod(input logic [DATA_W-1:0] x,
                                                       input logic [COEF_W-1:0] c,
                                                       input logic xs,
                                                       input logic cs);
    logic signed [DATA_W:0] xe;
    logic signed [COEF_W:0] ce;
    logic signed [DATA_W+COEF_W+1:0] p;
    xe = {xs & x[DATA_W-1], x}; // R14
    ce = {cs & c[COEF_W-1], c}; // R14
    p = xe * ce;
    return ACC_W'(p); // R15
  endfunction

  // ---------------- register port ----------------
  logic [FILTERS-1:0][LEN_W-1:0] len_q;
  sys_ctrl_t sys_q;
  logic bank_q;
  logic mode_2d_q;
  logic [BE_W-1:0] be_q;
  logic ovf_q;
  logic [31:0] rdata_q;
  logic [BANKS-1:0][FILTERS-1:0][TAPS-1:0][COEF_W-1:0] coef_q;
  logic fifo_room;

  wire [ADDR_W-1:0] addr = i_reg_req.addr;
  wire [31:0] wdata = i_reg_req.wdata;
  wire [FILTERS-1:0] hit_len;
  wire hit_sys = (addr == OFS_SYS);
  wire hit_arr = (addr == OFS_ARR);
  wire hit_be = (addr == OFS_BACKEND);
  wire hit_st = (addr == OFS_STATUS);
  wire arr_wr = i_reg_req.wr && hit_arr;
  wire hit_coef_page = (addr[ADDR_W-1:COEF_PAGE_LSB] == COEF_PAGE);
  wire c_bank = addr[COEF_BANK_BIT];
  wire [COEF_FILT_W-1:0] c_filt = addr[COEF_FILT_LSB +: COEF_FILT_W];
  wire [COEF_TAP_W-1:0] c_tap = addr[COEF_TAP_LSB +: COEF_TAP_W];
  wire c_in_range = hit_coef_page && (c_filt < FILTERS) && (c_tap < TAPS);
  // the bank in use is locked against writes; with continuous swap both banks run and both take writes
  wire coef_wr = i_reg_req.wr && c_in_range && (sys_q.swap || (c_bank != bank_q)); // R11

  for (genvar k = 0; k < FILTERS; k++) begin : g_hit
    assign hit_len[k] = (addr == OFS_LEN_FIRST + ADDR_W'(k) * OFS_LEN_STEP);
  end

  wire [31:0] st_word = 32'({fifo_room, ovf_q, bank_q});
  wire [31:0] rsel =
    hit_len[0] ? 32'(len_q[0]) :
    hit_len[1] ? 32'(len_q[1]) :
    hit_len[2] ? 32'(len_q[2]) :
    hit_sys ? 32'(sys_q) :
    hit_arr ? 32'({mode_2d_q, bank_q}) :
    hit_be ? 32'(be_q) :
    hit_st ? st_word :
    c_in_range ? 32'(coef_q[c_bank][c_filt][c_tap]) : 32'h0000_0000;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      len_q <= '0;
      sys_q <= SYS_RESET;
      mode_2d_q <= 1'b0;
      be_q <= '0;
    end else if (i_reg_req.wr) begin
      for (int k = 0; k < FILTERS; k++) begin
        if (hit_len[k]) len_q[k] <= clamp_len(wdata); // R1 R2
      end
      if (hit_sys) sys_q <= wdata[$bits(sys_ctrl_t)-1:0];
      if (hit_arr) mode_2d_q <= wdata[ARR_2D_BIT]; // R8
      if (hit_be) be_q <= wdata[BE_W-1:0];
    end
  end

  // one bank per clock, so all taps of a sample share it
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) bank_q <= 1'b0;
    else if (arr_wr) bank_q <= wdata[ARR_BANK_BIT]; // R12 R19
    else if (sys_q.swap) bank_q <= ~bank_q; // R13
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) coef_q <= '0;
    else if (coef_wr) coef_q[c_bank][c_filt][c_tap] <= wdata[COEF_W-1:0]; // R11
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) rdata_q <= '0;
    else rdata_q <= i_reg_req.rd ? rsel : 32'h0000_0000;
  end

  assign o_reg_rdata = rdata_q;

  // ---------------- line delay chain ----------------
  logic [DATA_W-1:0] in_q;
  logic [LAW-1:0] wp_q;
  logic [FILTERS:0][DATA_W-1:0] tap;
  logic [FILTERS-1:0][DATA_W-1:0] mem_rd;
  logic [PT_PAD-1:0][DATA_W-1:0] pt_q;
  logic [DATA_W-1:0] pt_out_q;

  assign tap[0] = in_q;

  for (genvar k = 0; k < FILTERS; k++) begin : g_line
    line_delay_mem #(.W(DATA_W), .DEPTH(LINE_DEPTH)) u_mem (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_waddr(wp_q),
      .i_wdata(tap[k]),
      .i_raddr(tap_addr(wp_q, len_q[k])),
      .o_rdata(mem_rd[k])
    );
    // a zero length passes the word straight on
    assign tap[k+1] = (len_q[k] == '0) ? tap[k] : mem_rd[k]; // R1 R3
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      in_q <= '0;
      wp_q <= '0;
      pt_q <= '0;
      pt_out_q <= '0;
    end else begin
      in_q <= i_line_chain_input;
      wp_q <= (wp_q == LAW'(LINE_DEPTH - 1)) ? '0 : wp_q + 1'b1;
      pt_q <= {pt_q[PT_PAD-2:0], tap[FILTERS]}; // R5
      pt_out_q <= sys_q.bypass ? in_q : pt_q[PT_PAD-1]; // R4
    end
  end

  assign o_line_chain_passthrough = pt_out_q;

  // ---------------- multiply-accumulate array ----------------
  logic signed [FILTERS-1:0][TAPS-1:0][ACC_W-1:0] s_q;
  logic signed [FILTERS-1:0][TAPS-1:0][ACC_W-1:0] prod;
  logic signed [FILTERS-1:0][TAPS-1:0][ACC_W-1:0] s_in;
  logic signed [FILTERS-1:0][ACC_W-1:0] link_q;
  logic [FILTERS-1:0][DATA_W-1:0] fx;

  for (genvar f = 0; f < FILTERS; f++) begin : g_filt
    // in line mode every filter sees the chain input directly
    assign fx[f] = mode_2d_q ? tap[f+1] : in_q; // R3 R8
    for (genvar t = 0; t < TAPS; t++) begin : g_tap
      assign prod[f][t] = mac_prod(fx[f], coef_q[bank_q][f][t],
                                   sys_q.data_signed, sys_q.coef_signed); // R9
      if (t == 0 && f == 0) begin : g_head
        assign s_in[f][t] = '0;
      end else if (t == 0) begin : g_link
        assign s_in[f][t] = link_q[f-1]; // R10
      end else begin : g_chain
        assign s_in[f][t] = s_q[f][t-1]; // R9
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      s_q <= '0;
      link_q <= '0;
    end else begin
      for (int f = 0; f < FILTERS; f++) begin
        for (int t = 0; t < TAPS; t++) begin
          s_q[f][t] <= s_in[f][t] + prod[f][t]; // R9 R15
        end
        link_q[f] <= s_q[f][TAPS-1]; // R10
      end
    end
  end

  // ---------------- shifter and cascade adder ----------------
  logic signed [ARRAY_PAD-1:0][ACC_W-1:0] pad_q;
  logic [CIN_PAD-1:0][ACC_W-1:0] cin_q;
  logic [ACC_W-1:0] cascade_result_bus_q;
  logic [ARRAY_LAT-1:0] vld_q;

  wire signed [ACC_W-1:0] arr_out = pad_q[ARRAY_PAD-1];
  wire [BE_SH_W-1:0] sh_raw = be_q[BE_SH_LSB +: BE_SH_W];
  wire [BE_SH_W-1:0] sh_amt = (sh_raw > BE_SH_W'(SH_MAX)) ? BE_SH_W'(SH_MAX) : sh_raw;
  wire be_zero = be_q[BE_ZERO_BIT];
  wire signed [ACC_W-1:0] sh_val = be_q[BE_LEFT_BIT] ? (arr_out <<< sh_amt)
                                                      : (arr_out >>> sh_amt); // R18
  wire [ACC_W-1:0] add_in = be_zero ? '0 : cin_q[CIN_PAD-1];
  wire [ACC_W-1:0] cascade_result_bus_d = sh_val + add_in; // R16 R18

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      pad_q <= '0;
      cin_q <= '0;
      cascade_result_bus_q <= '0;
      vld_q <= '0;
    end else begin
      pad_q <= {pad_q[ARRAY_PAD-2:0], s_q[FILTERS-1][TAPS-1]}; // R6
      cin_q <= {cin_q[CIN_PAD-2:0], i_cascade_in_bus}; // R7
      cascade_result_bus_q <= cascade_result_bus_d; // R7 R17
      vld_q <= {vld_q[ARRAY_LAT-2:0], i_sample_valid};
    end
  end

  assign o_cascade_result_bus = cascade_result_bus_q;

  // ---------------- result capture ----------------
  // the pipeline cannot stall, so a result meeting a full buffer is lost and flagged
  wire res_valid = vld_q[ARRAY_LAT-1];
  wire ovf_set = res_valid && !fifo_room;
  wire ovf_clr = i_reg_req.wr && hit_st && wdata[ST_OVF_BIT];

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) ovf_q <= 1'b0;
    else ovf_q <= ovf_set | (ovf_q & ~ovf_clr);
  end

  result_fifo #(.W(ACC_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_s_valid(res_valid),
    .o_s_ready(fifo_room),
    .i_s_data(cascade_result_bus_q),
    .o_m_valid(o_result_valid),
    .i_m_ready(i_result_ready),
    .o_m_data(o_result_data)
  );

  assign o_result_accept = fifo_room;

  // ---------------- checks ----------------
  logic [2:0] age_q;
  logic [2:0] zl_q;
  wire age_ok = (age_q == 3'(AGE_MAX));
  wire zl_ok = (zl_q == 3'(AGE_MAX));
  wire lens_zero = (len_q == '0) && !sys_q.bypass;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      age_q <= '0;
      zl_q <= '0;
    end else begin
      if (!age_ok) age_q <= age_q + 1'b1;
      if (!lens_zero) zl_q <= '0;
      else if (!zl_ok) zl_q <= zl_q + 1'b1;
    end
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  a_bypass_delay: assert property ( // R4
    age_ok && $past(sys_q.bypass) |-> o_line_chain_passthrough == $past(i_line_chain_input, 2))
    else $error("bypass passthrough not two cycles late");
  a_chain_fixed: assert property ( // R5
    zl_ok |-> o_line_chain_passthrough == $past(i_line_chain_input, 5))
    else $error("zero-length chain latency not five cycles");
  a_cascade_path: assert property ( // R7
    age_ok && !$past(be_zero) |->
      o_cascade_result_bus == ACC_W'($past(sh_val) + $past(i_cascade_in_bus, 6)))
    else $error("cascade path latency wrong");
  a_zero_select: assert property ( // R18
    $past(be_zero) |-> o_cascade_result_bus == $past(sh_val))
    else $error("zero select still adds cascade input");
  a_bank_swap: assert property ( // R13
    $past(sys_q.swap) && !$past(arr_wr) |-> bank_q != $past(bank_q))
    else $error("continuous swap did not exchange banks");
  a_bank_hold: assert property ( // R12
    !$past(sys_q.swap) && !$past(arr_wr) |-> $stable(bank_q) && $stable(coef_q[bank_q]))
    else $error("active bank changed without request");
  a_len_range: assert property ( // R1
    (len_q[0] <= LEN_W'(LINE_DEPTH)) && (len_q[1] <= LEN_W'(LINE_DEPTH))
      && (len_q[2] <= LEN_W'(LINE_DEPTH)))
    else $error("line delay length above maximum");
  a_filter_link: assert property ( // R10
    age_ok |-> s_q[1][0] == ACC_W'($past(s_q[0][TAPS-1], 2) + $past(prod[1][0])))
    else $error("filter link delay stage missing");
  a_tap_sum: assert property ( // R9
    age_ok |-> s_q[0][1] == ACC_W'($past(s_q[0][0]) + $past(prod[0][1])))
    else $error("tap does not add registered previous tap");

  c_bypass_used: cover property (sys_q.bypass ##2 $changed(o_line_chain_passthrough));
  c_swap_running: cover property (sys_q.swap ##1 sys_q.swap);
  c_fifo_overflow: cover property (ovf_set);
  c_result_drained: cover property (o_result_valid && i_result_ready);
endmodule // convolver_shift_mac_array

// >>> convolver_shift_mac_array_tb.sv
`timescale 1ns/1ps
module convolver_shift_mac_array_tb import conv_pkg::*;;
  localparam int LD = 16;
  localparam int FD = 32;
  logic i_core_clk;
  logic i_rst_b;
  reg_req_t req;
  logic [31:0] rdata;
  logic [DATA_W-1:0] smp;
  logic [DATA_W-1:0] pt;
  logic sv, tag, rdy, acc, rv;
  logic [ACC_W-1:0] cascade_in_bus, cas, rdat;
  int error_cnt, n_tests, cyc, pt_lat, cmode, k, cnt, alat, nq;
  logic hsv [256];
  logic [ACC_W-1:0] exq [32];
  logic [3:0] sysv;
  logic [7:0] cf;
  logic [7:0] hin [256];
  logic [ACC_W-1:0] hcin [256];

  initial begin
    i_core_clk = 1'b0;
    forever #2.5 i_core_clk = ~i_core_clk;
  end

  convolver_shift_mac_array #(.LINE_DEPTH(LD), .FIFO_DEPTH(FD)) DUT (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_reg_req(req), .o_reg_rdata(rdata),
    .i_line_chain_input(smp), .i_sample_valid(sv), .o_line_chain_passthrough(pt),
    .i_cascade_in_bus(cascade_in_bus), .o_cascade_result_bus(cas), .o_result_accept(acc),
    .o_result_valid(rv), .i_result_ready(rdy), .o_result_data(rdat));

  pixel_source src (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_tag(tag),
    .o_sample(smp), .o_valid(sv), .o_cascade(cascade_in_bus));

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_core_clk);
    req <= '0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge i_core_clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge i_core_clk);
    req <= '0;
    @(negedge i_core_clk);
    chk(rdata, e);
  endtask

  function automatic logic [ACC_W-1:0] prod(input logic [7:0] x);
    logic [ACC_W-1:0] a;
    logic [ACC_W-1:0] b;
    a = sysv[SYS_DSIGN_BIT] ? {{14{x[7]}}, x} : {14'h0, x};
    b = sysv[SYS_CSIGN_BIT] ? {{14{cf[7]}}, cf} : {14'h0, cf};
    return a * b;
  endfunction

  // long settle: line memories and the 47-deep array hold words from the old setup
  task automatic settle_check(input int lat, input int mode);
    pt_lat = 0;
    cmode = 0;
    repeat (60) @(posedge i_core_clk);
    pt_lat = lat;
    cmode = mode;
    repeat (30) @(posedge i_core_clk);
    pt_lat = 0;
    cmode = 0;
  endtask

  // history of what the far side presented in each cycle, outputs judged mid-cycle
  always @(negedge i_core_clk) begin
    cyc++;
    hin[cyc % 256] = smp;
    hcin[cyc % 256] = cascade_in_bus;
    hsv[cyc % 256] = sv;
    // the drain side stays stalled while tagged results arrive, so the first FD are kept
    if (cyc > 47 && hsv[(cyc - 47) % 256] === 1'b1 && nq < FD) begin
      exq[nq] = prod(hin[(cyc - 47) % 256]);
      nq++;
    end
    if (pt_lat > 0) chk(32'(pt), 32'(hin[(cyc - pt_lat) % 256]));
    if (cmode == 1) chk(32'(cas), 32'(hcin[(cyc - 6) % 256]));
    if (cmode == 2) chk(32'(cas), 32'(prod(hin[(cyc - alat) % 256])));
  end

  initial begin
    #50us;
    error_cnt++;
    complete_run;
  end

  initial begin
    i_rst_b = 1'b0;
    req = '0;
    tag = 1'b0;
    rdy = 1'b0;
    error_cnt = 0;
    n_tests = 0;
    cyc = 0;
    pt_lat = 0;
    cmode = 0;
    alat = 47;
    nq = 0;
    sysv = 4'h0;
    cf = 8'hfd;
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rd(OFS_STATUS, 32'h4);
    rd(OFS_SYS, 32'h0);
    rd(12'h0f0, 32'h0);
    settle_check(5, 1);
    wr(12'h1d8, 32'(cf));
    wr(OFS_BACKEND, 32'h1);
    wr(OFS_ARR, 32'h1);
    // the active bank is locked, so this must not disturb the product
    wr(12'h1d8, 32'h11);
    for (k = 0; k < 4; k++) begin
      sysv = 4'(k << 2);
      wr(OFS_SYS, 32'(sysv));
      settle_check(5, 2);
    end
    sysv = 4'h0;
    wr(OFS_SYS, 32'h2);
    settle_check(2, 0);
    wr(OFS_LEN_FIRST, 32'h7ff);
    rd(OFS_LEN_FIRST, 32'(LD));
    wr(OFS_LEN_FIRST, 32'h1);
    wr(12'h004, 32'h2);
    wr(12'h008, 32'h3);
    wr(OFS_SYS, 32'h0);
    settle_check(11, 0);
    // window mode: filter 2 reads the third delay, six cycles of line delay later
    wr(OFS_ARR, 32'h3);
    alat = 53;
    settle_check(11, 2);
    wr(OFS_ARR, 32'h1);
    alat = 47;
    settle_check(11, 2);
    // fill with the drain side stalled until the buffer refuses
    tag <= 1'b1;
    repeat (80) @(posedge i_core_clk);
    tag <= 1'b0;
    repeat (60) @(posedge i_core_clk);
    @(negedge i_core_clk);
    chk(32'(acc), 32'h0);
    rd(OFS_STATUS, 32'h3);
    @(posedge i_core_clk);
    rdy <= 1'b1;
    cnt = 0;
    repeat (100) begin
      @(negedge i_core_clk);
      if (rv === 1'b1) begin
        if (cnt < FD) chk(32'(rdat), 32'(exq[cnt]));
        cnt++;
      end
    end
    chk(32'(cnt), 32'(FD));
    chk(32'(rv), 32'h0);
    wr(OFS_STATUS, 32'h2);
    rd(OFS_STATUS, 32'h5);
    // run continuous swap a few samples, then reload the bank and read it back
    wr(OFS_SYS, 32'h1);
    repeat (6) @(posedge i_core_clk);
    wr(OFS_SYS, 32'h0);
    wr(OFS_ARR, 32'h1);
    rd(OFS_ARR, 32'h1);
    complete_run;
  end
endmodule // convolver_shift_mac_array_tb

// >>> line_delay_mem.sv
`timescale 1ns/1ps
module line_delay_mem #(
  parameter int W = 8,
  parameter int DEPTH = 1120,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [DEPTH];
  logic [W-1:0] rdata_q;
  // same-address read returns the word being written, so a length of one works
  wire fwd = (i_waddr == i_raddr);
  wire [W-1:0] rdata_d = fwd ? i_wdata : mem[i_raddr];

  always_ff @(posedge i_core_clk) begin
    mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) rdata_q <= '0;
    else rdata_q <= rdata_d;
  end

  assign o_rdata = rdata_q;
endmodule // line_delay_mem

// >>> pixel_source.sv
`timescale 1ns/1ps
module pixel_source import conv_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_tag,
  output logic [DATA_W-1:0] o_sample,
  output logic o_valid,
  output logic [ACC_W-1:0] o_cascade
);
  // a new sample and a neighbour's partial sum every clock, no stall
  // odd steps walk all byte values, so signed and unsigned readings both get exercised
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      o_sample <= 8'h00;
      o_valid <= 1'b0;
      o_cascade <= 22'h000000;
    end else begin
      o_sample <= o_sample + 8'h35;
      o_valid <= i_tag;
      o_cascade <= o_cascade + 22'h02a5c3;
    end
  end
endmodule // pixel_source

// >>> result_fifo.sv
`timescale 1ns/1ps
module result_fifo #(
  parameter int W = 22,
  parameter int DEPTH = 32,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_s_valid,
  output logic o_s_ready,
  input wire logic [W-1:0] i_s_data,
  output logic o_m_valid,
  input wire logic i_m_ready,
  output logic [W-1:0] o_m_data
);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire empty = (wp_q == rp_q);
  wire full = (wp_q[AW-1:0] == rp_q[AW-1:0]) && (wp_q[AW] != rp_q[AW]);
  wire push = i_s_valid && !full;
  wire pop = i_m_ready && !empty;

  always_ff @(posedge i_core_clk) begin
    if (push) mem[wp_q[AW-1:0]] <= i_s_data;
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_b) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end

  assign o_s_ready = !full;
  assign o_m_valid = !empty;
  assign o_m_data = mem[rp_q[AW-1:0]];
endmodule // result_fifo
